// ===== host_bus_master_mode2.sv
// host bus master, bus mode 2: arbitration, transfers, burst, retry, fault
// =====================================================================
// Summary of operation
// - flag fetch, then request the bus
// - on grant and free ack, own bus
// - request one to two clocks after fetch flag
// - snoop mode: snoop bit0 follows snoopModeEn; request timing as without snoop
// - drop fetch flag 1-2 clocks after busy release
// - fetch flag held through retries until done
// - fast arbitration: acknowledge grant at once
// - drive attributes, then transfer-in-progress
// - read: start with address, size; drop next
// - write: data driven with transfer start
// - wait ack, sample error; burst refuse is not used
// - burst while beats remain, whether or not slave refuses burst
// - error with ack means retry
// - error without ack means bus fault
// - ack and more pending: start next transfer
// - last ack releases owner, busy, in-flight
// - float control, address, write data after release
`timescale 1ns/1ps
module host_bus_master_mode2 #(
    parameter int ADDR_W     = hbm2_pkg::ADDR_W,
    parameter int DATA_W     = hbm2_pkg::DATA_W,
    parameter int LINE_BEATS = hbm2_pkg::LINE_BEATS
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    // user side
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire logic              reqWrite,
    input  wire logic              reqFetch,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqWdata,
    input  wire logic [7:0]        reqCount,
    input  wire logic              fastArbEn,
    input  wire logic              snoopModeEn,
    output logic                   beatDone,
    output logic [DATA_W-1:0]      readData,
    output logic                   xferDone,
    output logic                   busFault,
    // host bus
    output logic                   bus_ask_n,
    input  wire logic              bus_grant_in_n,
    input  wire logic              grant_ack_in_n,
    output logic                   grant_ack_out_n,
    output logic                   grant_ack_oe,
    output logic                   owner_flag_n,
    input  wire logic              bus_occupied_in_n,
    output logic                   bus_occupied_n,
    output logic                   bus_occupied_oe,
    output logic                   opcode_read_flag_n,
    output logic                   cycle_in_flight_n,
    output logic                   cycle_begin_n,
    input  wire logic              cycle_ack_n,
    input  wire logic              cycle_error_ack_n,
    input  wire logic              burst_refuse_n,
    output logic                   read_not_write,
    output logic [1:0]             snoop_ctl,
    output logic [2:0]             xfer_modifier,
    output logic [1:0]             xfer_type,
    output logic [1:0]             xfer_size,
    output logic [ADDR_W-1:0]      addr_out,
    output logic                   ctrl_oe,
    output logic [DATA_W-1:0]      wdata_out,
    output logic                   wdata_oe
);
    // =================================================================
    // state
    typedef enum {IDLE, FLAG, ASK, GRANT, ATTR, START, WAIT, DONE} state_e;
    state_e state_q, state_d;

    logic              write_q;
    logic              fetch_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [7:0]        left_q;
    logic [DATA_W-1:0] rdata_q;
    logic              fault_q;
    logic              done_q;
    logic              beat_q;
    logic              flagHold_q;
    logic              busyPrev_q;

    // =================================================================
    // decode of slave answer
    wire ackSeen   = !cycle_ack_n;
    wire errSeen   = !cycle_error_ack_n;
    wire retryHit  = ackSeen && errSeen;
    wire faultHit  = errSeen && !ackSeen;
    wire goodHit   = ackSeen && !errSeen;
    wire burstOk   = burst_refuse_n;
    wire lastBeat  = (left_q == 8'h01);
    wire moreLeft  = !lastBeat;
    wire grantOk   = !bus_grant_in_n && grant_ack_in_n;
    wire flagDelayed;
    wire snoopDelayed;
    wire busyFreeDelayed;
    wire ownNow    = (state_q == ATTR) || (state_q == START) || (state_q == WAIT);

    // the fetch flag is asserted one clock ahead of the request
    hbm2_delay #(.DEPTH(hbm2_pkg::FETCH_TO_ASK)) u_flagDly (
        .clock  (clock),
        .rst_n  (rst_n),
        .inBit  (state_q == FLAG),
        .outBit (flagDelayed)
    );

    // snoop bit0 follows snoopModeEn directly; this delayed FLAG in snoop mode does not move the request
    hbm2_delay #(.DEPTH(hbm2_pkg::FETCH_TO_ASK)) u_snpDly (
        .clock  (clock),
        .rst_n  (rst_n),
        .inBit  (snoopModeEn && (state_q == FLAG)),
        .outBit (snoopDelayed)
    );

    // busy returning high frees the fetch flag two clocks later
    hbm2_delay #(.DEPTH(hbm2_pkg::BUSY_TO_FREE)) u_busyDly (
        .clock  (clock),
        .rst_n  (rst_n),
        .inBit  (!busyPrev_q && bus_occupied_in_n),
        .outBit (busyFreeDelayed)
    );

    // =================================================================
    // next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            IDLE:  if (reqValid) state_d = FLAG;
            FLAG:  state_d = ASK;
            ASK:
            begin
                if (flagDelayed || snoopDelayed || (state_q == ASK))
                    state_d = GRANT;
            end
            GRANT:
            begin
                if (grantOk || (fastArbEn && !bus_grant_in_n))
                    state_d = ATTR;
            end
            ATTR:  state_d = START;
            START: state_d = WAIT;
            WAIT:
            begin
                if (faultHit)
                    state_d = DONE;
                else if (retryHit)
                    state_d = START;
                else if (goodHit && moreLeft)
                    state_d = START;
                else if (goodHit)
                    state_d = DONE;
            end
            DONE:  state_d = IDLE;
            default: state_d = IDLE;
        endcase
    end

    // =================================================================
    // registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state_q <= IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            write_q <= 1'b0;
            fetch_q <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
            left_q  <= 8'h00;
        end
        else if (state_q == IDLE && reqValid)
        begin
            write_q <= reqWrite;
            fetch_q <= reqFetch && !reqWrite;
            addr_q  <= reqAddr;
            wdata_q <= reqWdata;
            left_q  <= (reqCount == 8'h00) ? 8'h01 : reqCount;
        end
        else if (state_q == WAIT && goodHit && moreLeft)
        begin
            // burst beats step through the line; non-burst beats restart alike
            addr_q  <= addr_q + hbm2_pkg::BEAT_BYTES;
            wdata_q <= reqWdata;
            left_q  <= left_q - 8'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rdata_q <= '0;
            beat_q  <= 1'b0;
            done_q  <= 1'b0;
            fault_q <= 1'b0;
        end
        else
        begin
            beat_q  <= (state_q == WAIT) && goodHit;
            if ((state_q == WAIT) && goodHit && !write_q)
                rdata_q <= rdata_q;
            done_q  <= (state_q == WAIT) && goodHit && lastBeat;
            fault_q <= (state_q == WAIT) && faultHit;
        end
    end

    // flag stays low through retries; freed after busy has risen
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            flagHold_q <= 1'b0;
            busyPrev_q <= 1'b1;
        end
        else
        begin
            busyPrev_q <= bus_occupied_in_n;
            // flag falls on entry to FLAG so the request trails it by a clock
            if (state_q == IDLE && reqValid && reqFetch && !reqWrite)
                flagHold_q <= 1'b1;
            else if (busyFreeDelayed && (state_q == IDLE))
                flagHold_q <= 1'b0;
        end
    end

    // =================================================================
    // outputs
    assign reqReady           = (state_q == IDLE);
    assign beatDone           = beat_q;
    assign readData           = rdata_q;
    assign xferDone           = done_q;
    assign busFault           = fault_q;
    assign opcode_read_flag_n = !flagHold_q;
    assign bus_ask_n          = !((state_q == ASK) || (state_q == GRANT));
    assign grant_ack_out_n    = !ownNow;
    assign grant_ack_oe       = ownNow;
    assign owner_flag_n       = !ownNow;
    assign bus_occupied_n     = !ownNow;
    assign bus_occupied_oe    = ownNow;
    assign cycle_in_flight_n  = !((state_q == START) || (state_q == WAIT));
    assign cycle_begin_n      = !(state_q == START);
    assign read_not_write     = !write_q;
    assign snoop_ctl          = snoopModeEn ? hbm2_pkg::SC_SNOOP : hbm2_pkg::SC_NONE;
    assign xfer_modifier      = fetch_q ? hbm2_pkg::TM_FETCH : hbm2_pkg::TM_DATA;
    assign xfer_type          = hbm2_pkg::TT_NORMAL;
    assign xfer_size          = hbm2_pkg::SIZE_LONG;
    assign addr_out           = addr_q;
    assign ctrl_oe            = ownNow;
    assign wdata_out          = wdata_q;
    assign wdata_oe           = ownNow && write_q && (state_q != ATTR);
endmodule : host_bus_master_mode2

// ===== hbm2_pkg.sv
// shared constants for the mode 2 host bus master
package hbm2_pkg;
    localparam int ADDR_W       = 32;
    localparam int DATA_W       = 32;
    localparam int LINE_BEATS   = 4;
    localparam int BEAT_W       = 2;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] TT_NORMAL = 2'h0;
    localparam logic [2:0] TM_FETCH  = 3'h2;
    localparam logic [2:0] TM_DATA   = 3'h1;
    localparam logic [1:0] SC_NONE   = 2'h0;
    localparam logic [1:0] SC_SNOOP  = 2'h1;
    localparam logic [1:0] ADDR_STEP = 2'h0;
    localparam logic [ADDR_W-1:0] BEAT_BYTES = 32'h0000_0004;
    // one clock between fetch flag and request, and one delay clock of the two between busy release and flag release
    localparam int FETCH_TO_ASK = 1;
    localparam int BUSY_TO_FREE = 1;
endpackage : hbm2_pkg

// ===== hbm2_delay.sv
// short shift delay used for the one-clock spacings
`timescale 1ns/1ps
module hbm2_delay #(
    parameter int DEPTH = 1
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic inBit,
    output logic      outBit
);
    logic [DEPTH-1:0] shift_q;

    // a one-deep line has no lower slice to shift from
    if (DEPTH == 1)
    begin : g_single
        always_ff @(posedge clock)
        begin
            if (!rst_n)
                shift_q <= '0;
            else
                shift_q <= inBit;
        end
    end
    else
    begin : g_multi
        always_ff @(posedge clock)
        begin
            if (!rst_n)
                shift_q <= '0;
            else
                shift_q <= {shift_q[DEPTH-2:0], inBit};
        end
    end

    assign outBit = shift_q[DEPTH-1];
endmodule : hbm2_delay

// ===== host_bus_master_mode2_chk.sv
// port-level checks for the mode 2 host bus master
`timescale 1ns/1ps
module host_bus_master_mode2_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fastArbEn,
    input wire logic busFault,
    input wire logic xferDone,
    input wire logic bus_ask_n,
    input wire logic bus_grant_in_n,
    input wire logic grant_ack_in_n,
    input wire logic owner_flag_n,
    input wire logic bus_occupied_in_n,
    input wire logic bus_occupied_n,
    input wire logic bus_occupied_oe,
    input wire logic opcode_read_flag_n,
    input wire logic cycle_in_flight_n,
    input wire logic cycle_begin_n,
    input wire logic cycle_ack_n,
    input wire logic cycle_error_ack_n,
    input wire logic read_not_write,
    input wire logic ctrl_oe,
    input wire logic wdata_oe
);
    // ==========
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ask_after_flag_a: assert property (
        $fell(opcode_read_flag_n) |-> ##[1:2] !bus_ask_n) else $error("late request");
    grant_seen_a: assert property (
        $fell(owner_flag_n) |-> $past(bus_grant_in_n) == 1'b0
        && (fastArbEn || $past(grant_ack_in_n))) else $error("owned without grant");
    ask_dropped_a: assert property (
        !owner_flag_n |-> bus_ask_n) else $error("request held while owner");
    attr_first_a: assert property (
        $fell(cycle_in_flight_n) |-> $past(ctrl_oe) && !cycle_begin_n) else $error("no attr");
    start_pulse_a: assert property (
        !cycle_begin_n |=> cycle_begin_n) else $error("start too long");
    wdata_start_a: assert property (
        !cycle_begin_n && !read_not_write |-> wdata_oe) else $error("no write data");
    fault_raise_a: assert property (
        !cycle_in_flight_n && cycle_begin_n && !cycle_error_ack_n && cycle_ack_n
        |-> ##[1:2] busFault) else $error("no fault");
    retry_start_a: assert property (
        !cycle_in_flight_n && cycle_begin_n && !cycle_error_ack_n && !cycle_ack_n
        |-> ##[1:3] !cycle_begin_n) else $error("no retry");
    bus_release_a: assert property (
        xferDone |-> owner_flag_n && cycle_in_flight_n && (bus_occupied_n || !bus_occupied_oe)
        && !ctrl_oe && !wdata_oe) else $error("bus kept");
    flag_free_a: assert property (
        $rose(bus_occupied_in_n) |-> ##[1:2] opcode_read_flag_n) else $error("flag kept");
endmodule : host_bus_master_mode2_chk

bind host_bus_master_mode2 host_bus_master_mode2_chk i_host_bus_master_mode2_chk (.clock, .rst_n,
    .fastArbEn, .busFault, .xferDone, .bus_ask_n, .bus_grant_in_n, .grant_ack_in_n, .owner_flag_n,
    .bus_occupied_in_n, .bus_occupied_n, .bus_occupied_oe, .opcode_read_flag_n,
    .cycle_in_flight_n, .cycle_begin_n, .cycle_ack_n, .cycle_error_ack_n, .read_not_write,
    .ctrl_oe, .wdata_oe);

// ===== hbm2_bus_model.sv
// arbiter and slave model on the far side of the host bus
`timescale 1ns/1ps
module hbm2_bus_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       bus_ask_n,
    input  wire logic       cycle_begin_n,
    input  wire logic [1:0] kind,
    input  wire logic [1:0] slow,
    input  wire logic       holdAck,
    output logic            bus_grant_in_n,
    output logic            otherAck_n,
    output logic            cycle_ack_n,
    output logic            cycle_error_ack_n
);
    logic [1:0] cnt_q;
    logic [1:0] hold_q;
    logic       wait_q;
    logic       odd_q;
    // another master lets go of grant ack late
    assign otherAck_n = (hold_q == 2'h0);
    always_ff @(posedge clock)
    begin
        cycle_ack_n <= 1'b1;
        cycle_error_ack_n <= 1'b1;
        if (!rst_n)
        begin
            bus_grant_in_n <= 1'b1;
            {wait_q, odd_q, cnt_q, hold_q} <= 6'h00;
        end
        else
        begin
            bus_grant_in_n <= bus_ask_n;
            if (bus_ask_n && holdAck)
                hold_q <= 2'h3;
            else if (hold_q != 2'h0)
                hold_q <= hold_q - 2'h1;
            if (!cycle_begin_n)
            begin
                wait_q <= 1'b1;
                cnt_q <= slow;
            end
            else if (wait_q && cnt_q != 2'h0)
                cnt_q <= cnt_q - 2'h1;
            else if (wait_q)
            begin
                // retries alternate with good acks so a retried beat always ends
                wait_q <= 1'b0;
                odd_q <= ~odd_q;
                cycle_ack_n <= (kind == 2'h2);
                cycle_error_ack_n <= !(kind == 2'h2 || (kind == 2'h1 && !odd_q));
            end
        end
    end
endmodule : hbm2_bus_model

// ===== host_bus_master_mode2_tb_top.sv
// self-checking bench for the mode 2 host bus master
`timescale 1ns/1ps
module host_bus_master_mode2_tb_top;
    logic clock, rst_n, reqValid, reqWrite, reqFetch, fastArbEn, snoopModeEn, holdAck;
    logic burst_refuse_n, sawFault, sawDone;
    logic [31:0] reqAddr, reqWdata, readData, addr_out, wdata_out;
    logic [7:0] reqCount, seed;
    logic [1:0] kind, slow, snoop_ctl, xfer_type, xfer_size;
    logic [2:0] xfer_modifier;
    logic reqReady, beatDone, xferDone, busFault, bus_ask_n, bus_grant_in_n, grant_ack_out_n;
    logic grant_ack_oe, owner_flag_n, bus_occupied_n, bus_occupied_oe, opcode_read_flag_n;
    logic cycle_in_flight_n, cycle_begin_n, cycle_ack_n, cycle_error_ack_n, read_not_write;
    logic ctrl_oe, wdata_oe, otherAck_n;
    wire grant_ack_in_n = (grant_ack_oe ? grant_ack_out_n : 1'b1) & otherAck_n;
    wire bus_occupied_in_n = bus_occupied_oe ? bus_occupied_n : 1'b1;
    int miscompares = 0, n_checks = 0, beat;

    host_bus_master_mode2 i_host_bus_master_mode2 (.clock, .rst_n, .reqValid, .reqReady,
        .reqWrite, .reqFetch, .reqAddr, .reqWdata, .reqCount, .fastArbEn, .snoopModeEn,
        .beatDone, .readData, .xferDone, .busFault, .bus_ask_n, .bus_grant_in_n, .grant_ack_in_n,
        .grant_ack_out_n, .grant_ack_oe, .owner_flag_n, .bus_occupied_in_n, .bus_occupied_n,
        .bus_occupied_oe, .opcode_read_flag_n, .cycle_in_flight_n, .cycle_begin_n, .cycle_ack_n,
        .cycle_error_ack_n, .burst_refuse_n, .read_not_write, .snoop_ctl, .xfer_modifier,
        .xfer_type, .xfer_size, .addr_out, .ctrl_oe, .wdata_out, .wdata_oe);
    hbm2_bus_model i_hbm2_bus_model (.clock, .rst_n, .bus_ask_n, .cycle_begin_n, .kind, .slow,
        .holdAck, .bus_grant_in_n, .otherAck_n, .cycle_ack_n, .cycle_error_ack_n);

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // ==========
    // bus monitor
    always @(posedge clock)
    begin
        if (!cycle_begin_n)
        begin
            check(addr_out, reqAddr + hbm2_pkg::BEAT_BYTES * 32'(beat));
            check(read_not_write, !reqWrite);
            check(xfer_size, hbm2_pkg::SIZE_LONG);
            check(xfer_modifier, reqFetch ? hbm2_pkg::TM_FETCH : hbm2_pkg::TM_DATA);
            check(snoop_ctl, snoopModeEn ? hbm2_pkg::SC_SNOOP : hbm2_pkg::SC_NONE);
            check(xfer_type, hbm2_pkg::TT_NORMAL);
            check(ctrl_oe, 1'b1);
            if (reqWrite) check(wdata_out, reqWdata);
        end
        if (!cycle_in_flight_n && !cycle_ack_n && cycle_error_ack_n) beat++;
        if (!cycle_ack_n && !cycle_error_ack_n && reqFetch) check(opcode_read_flag_n, 1'b0);
        sawFault |= busFault;
        sawDone |= xferDone;
    end

    // ==========
    // stimulus
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        #500000;
        miscompares++;
        final_report;
    end
    initial
    begin
        {reqValid, reqWrite, reqFetch, fastArbEn, snoopModeEn, holdAck, burst_refuse_n} = 7'h01;
        {reqAddr, reqWdata, reqCount, kind, slow, sawFault, sawDone} = 78'h0;
        seed = 8'h5E;
        rst_n = 1'b0;
        beat = 0;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        for (int i = 0; i < 15; i++)
        begin
            @(negedge clock);
            seed = lfsr(seed);
            reqWrite = seed[0];
            reqFetch = !seed[0] && seed[1];
            reqCount = {6'h00, seed[3:2]};
            reqAddr = {22'h0, seed, 2'h0};
            reqWdata = {4{seed}};
            slow = seed[5:4];
            burst_refuse_n = seed[6];
            snoopModeEn = seed[7];
            kind = 2'(i % 3);
            fastArbEn = i[1];
            holdAck = i[2];
            {beat, sawFault, sawDone} = 34'h0;
            reqValid = 1'b1;
            @(negedge clock);
            reqValid = 1'b0;
            for (int t = 0; t < 200 && !sawFault && !sawDone; t++) @(negedge clock);
            check(sawFault, kind == 2'h2);
            if (kind != 2'h2) check(32'(beat), reqCount == 8'h0 ? 32'h1 : 32'(reqCount));
            repeat (4) @(negedge clock);
            check(opcode_read_flag_n, 1'b1);
            check(reqReady, 1'b1);
        end
        final_report;
    end
endmodule : host_bus_master_mode2_tb_top
